// ### hdl/key_press_filter.v
/*
 Debounce and press detector for one front-panel key.
 Assumes the raw key level is synchronous to the clock, high while pressed.
*/
`timescale 1ns/1ps
`default_nettype none

module key_press_filter #(
    parameter STABLE_CYC = 250000
) (
    input wire ref_clk_in,
    input wire rstn_in,
    input wire key_in,
    output reg press_out
);

    reg [31:0] count;
    reg stable;

    // ----------------------------------------
    // Filter
    // ----------------------------------------
    // Level must hold for STABLE_CYC cycles before it is believed;
    // a press pulses once on the accepted rising level only
    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            count <= 32'h0;
            stable <= 1'b0;
            press_out <= 1'b0;
        end else begin
            press_out <= 1'b0;
            if (key_in == stable) begin
                count <= 32'h0;
            end else if (count >= STABLE_CYC - 1) begin
                count <= 32'h0;
                stable <= key_in;
                press_out <= key_in;
            end else begin
                count <= count + 32'h1;
            end
        end
    end

endmodule

`default_nettype wire

// ### hdl/servo_panel_status_display.v
/*
 Front-panel operator logic: four keys, basic mode selection, value
 editing and the status display (seven bit segments and a state code).
 Assumes drive conditions arrive as synchronous levels and numbers
 from the motor control logic, and software uses the plain register port.
*/
`timescale 1ns/1ps
`default_nettype none
`include "servo_panel_defines.vh"

// How it works
// - Mode key advances to another basic mode
// - Increment key raises edited value one step
// - Decrement key lowers edited value one step
// - Data key opens value, then shifts digit
// - After settling, start in status display
// - Two bit-data digits plus state code
// - Segment meanings follow control mode
// - Speed: segment 1 on speed match
// - Torque: segment 1 always lit
// - Segment 2 lit while servo disabled
// - Segment 3 lit with control power
// - Speed/torque: segment 4 on speed reference
// - Position: segment 4 on reference pulses
// - Speed/torque: segment 5 on torque reference
// - Position: segment 5 on deviation clear
// - Segment 6 lit when main power normal
// - Segment 7 lit when motor rotating
// - State code covers eleven drive states
// - Data key in status mode during alarm clears alarm
// - Prohibit codes follow overtravel inputs
module servo_panel_status_display #(
    parameter SETTLE_CYC = `SETTLE_CYC,
    parameter DEBOUNCE_CYC = `DEBOUNCE_CYC,
    parameter VW = 16
) (
    input wire ref_clk_in,
    input wire rstn_in,
    input wire [3:0] addr_in,
    input wire [31:0] wr_data_in,
    input wire wr_en_in,
    input wire rd_en_in,
    output reg [31:0] rd_data_out,
    input wire key_mode_in,
    input wire key_up_in,
    input wire key_down_in,
    input wire key_data_in,
    input wire signed [VW-1:0] motor_speed_in,
    input wire signed [VW-1:0] speed_ref_in,
    input wire signed [VW-1:0] torque_ref_in,
    input wire signed [VW-1:0] position_error_in,
    input wire ref_pulse_active_in,
    input wire deviation_clear_in,
    input wire servo_on_in,
    input wire control_power_in,
    input wire main_power_ok_in,
    input wire forward_travel_limit_in,
    input wire reverse_travel_limit_in,
    input wire init_fail_in,
    input wire alarm_in,
    input wire quick_stop_in,
    input wire safe_state_in,
    output reg [1:0] basic_mode_out,
    output reg [6:0] bit_data_out,
    output reg [3:0] state_code_out,
    output reg panel_ready_out,
    output reg edit_open_out,
    output reg [2:0] edit_digit_out,
    output reg [VW-1:0] edit_value_out,
    output reg alarm_clear_out
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    reg [2:0] ctrl;
    reg [VW-1:0] speed_match_threshold;
    reg [VW-1:0] position_window_setting;
    reg [VW-1:0] rotation_threshold;
    reg [VW-1:0] torque_level;
    reg [31:0] settle_count;
    reg [6:0] next_bits;
    reg [3:0] next_code;
    wire [3:0] raw_key;
    wire [3:0] press;
    wire press_mode;
    wire press_up;
    wire press_down;
    wire press_data;
    wire [1:0] control_mode;
    wire alarm_num_sel;
    wire [VW-1:0] speed_diff;
    wire [VW-1:0] speed_ref_mag;
    wire [VW-1:0] torque_ref_mag;
    wire [VW-1:0] motor_speed_mag;
    wire [VW-1:0] pos_err_mag;
    wire [VW-1:0] step;
    wire [31:0] status_word;

    // Magnitude of a signed value; the most negative value keeps its own bit pattern
    function [VW-1:0] mag;
        input [VW-1:0] v;
        begin
            if (v[VW-1]) begin
                mag = ~v + {{(VW-1){1'b0}}, 1'b1};
            end else begin
                mag = v;
            end
        end
    endfunction

    // Weight of the active editing digit
    function [VW-1:0] weight;
        input [2:0] d;
        begin
            case (d)
                3'h0: weight = 16'h0001;
                3'h1: weight = 16'h000A;
                3'h2: weight = 16'h0064;
                3'h3: weight = 16'h03E8;
                3'h4: weight = 16'h2710;
                default: weight = 16'h0001;
            endcase
        end
    endfunction

    // ----------------------------------------
    // Key filters
    // ----------------------------------------
    assign raw_key = {key_data_in, key_down_in, key_up_in, key_mode_in};

    genvar k;
    generate
        for (k = 0; k < 4; k = k + 1) begin : g_key
            key_press_filter #(
                .STABLE_CYC(DEBOUNCE_CYC)
            ) u_filter (
                .ref_clk_in(ref_clk_in),
                .rstn_in(rstn_in),
                .key_in(raw_key[k]),
                .press_out(press[k])
            );
        end
    endgenerate

    // Keys count only once the panel has settled
    assign press_mode = press[0] & panel_ready_out;
    assign press_up = press[1] & panel_ready_out;
    assign press_down = press[2] & panel_ready_out;
    assign press_data = press[3] & panel_ready_out;

    // ----------------------------------------
    // Derived quantities
    // ----------------------------------------
    assign control_mode = ctrl[`CTRL_MODE_LSB +: 2];
    assign alarm_num_sel = ctrl[`CTRL_ALNUM_BIT];
    assign speed_diff = mag(motor_speed_in - speed_ref_in);
    assign speed_ref_mag = mag(speed_ref_in);
    assign torque_ref_mag = mag(torque_ref_in);
    assign motor_speed_mag = mag(motor_speed_in);
    assign pos_err_mag = mag(position_error_in);
    assign step = weight(edit_digit_out);

    // ----------------------------------------
    // Settling after power-up
    // ----------------------------------------
    // hold keys and bit segments off until settled; state code runs from reset
    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            settle_count <= 32'h0;
            panel_ready_out <= 1'b0;
        end else if (!panel_ready_out) begin
            if (settle_count >= SETTLE_CYC - 1) begin
                panel_ready_out <= 1'b1;
            end else begin
                settle_count <= settle_count + 32'h1;
            end
        end
    end

    // ----------------------------------------
    // Basic mode and editing
    // ----------------------------------------
    // Mode key also closes any open value, so a new mode starts clean
    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            basic_mode_out <= `BM_STATUS;
            edit_open_out <= 1'b0;
            edit_digit_out <= 3'h0;
            edit_value_out <= {VW{1'b0}};
            alarm_clear_out <= 1'b0;
        end else begin
            alarm_clear_out <= 1'b0;
            if (press_mode) begin
                basic_mode_out <= basic_mode_out + 2'h1;
                edit_open_out <= 1'b0;
                edit_digit_out <= 3'h0;
            end else if (press_data) begin
                if (basic_mode_out == `BM_STATUS) begin
                    alarm_clear_out <= alarm_in;
                end else if (!edit_open_out) begin
                    edit_open_out <= 1'b1;
                    edit_digit_out <= 3'h0;
                end else begin
                    if (edit_digit_out == `LAST_DIGIT) begin
                        edit_digit_out <= 3'h0;
                    end else begin
                        edit_digit_out <= edit_digit_out + 3'h1;
                    end
                end
            end else if (press_up && edit_open_out) begin
                edit_value_out <= edit_value_out + step;
            end else if (press_down && edit_open_out) begin
                edit_value_out <= edit_value_out - step;
            end else if (wr_en_in && addr_in == `REG_EDIT_VALUE) begin
                edit_value_out <= wr_data_in[VW-1:0];
            end
        end
    end

    // ----------------------------------------
    // Bit data segments
    // ----------------------------------------
    // segment meaning depends on control mode
    always @* begin
        next_bits = 7'h00;
        if (control_mode == `CM_POSITION) begin
            next_bits[0] = pos_err_mag < position_window_setting;
            next_bits[3] = ref_pulse_active_in;
            next_bits[4] = deviation_clear_in;
        end else begin
            if (control_mode == `CM_TORQUE) begin
                next_bits[0] = 1'b1;
            end else begin
                next_bits[0] = speed_diff <= speed_match_threshold;
            end
            next_bits[3] = speed_ref_mag > rotation_threshold;
            next_bits[4] = torque_ref_mag > torque_level;
        end
        next_bits[1] = !servo_on_in;
        next_bits[2] = control_power_in;
        next_bits[5] = main_power_ok_in;
        next_bits[6] = motor_speed_mag > rotation_threshold;
    end

    // ----------------------------------------
    // State code
    // ----------------------------------------
    // priority from hardest fault down to servo off
    always @* begin
        if (init_fail_in) begin
            next_code = `SC_INIT_FAIL;
        end else if (alarm_in) begin
            next_code = alarm_num_sel ? `SC_ALARM_NUM : `SC_ALARM;
        end else if (safe_state_in) begin
            next_code = `SC_SAFE;
        end else if (quick_stop_in) begin
            next_code = `SC_QUICK_STOP;
        end else if (forward_travel_limit_in && reverse_travel_limit_in) begin
            next_code = `SC_OVERTRAVEL;
        end else if (forward_travel_limit_in) begin
            next_code = `SC_FWD_PROHIBIT;
        end else if (reverse_travel_limit_in) begin
            next_code = `SC_REV_PROHIBIT;
        end else if (servo_on_in) begin
            next_code = `SC_RUN;
        end else if (main_power_ok_in) begin
            next_code = `SC_READY;
        end else begin
            next_code = `SC_SERVO_OFF;
        end
    end

    // ----------------------------------------
    // Display registers
    // ----------------------------------------
    // bit digits shown in status mode only; code follows in every mode
    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bit_data_out <= 7'h00;
            state_code_out <= `SC_SERVO_OFF;
        end else if (panel_ready_out && basic_mode_out == `BM_STATUS) begin
            bit_data_out <= next_bits;
            state_code_out <= next_code;
        end else begin
            bit_data_out <= 7'h00;
            state_code_out <= next_code;
        end
    end

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    // Thresholds steer the segment comparisons directly
    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctrl <= `CTRL_RESET;
            speed_match_threshold <= `SPEED_MATCH_RESET;
            position_window_setting <= `POS_WINDOW_RESET;
            rotation_threshold <= `ROT_THR_RESET;
            torque_level <= `TORQUE_LVL_RESET;
        end else if (wr_en_in) begin
            case (addr_in)
                `REG_CTRL: ctrl <= wr_data_in[2:0];
                `REG_SPEED_MATCH: speed_match_threshold <= wr_data_in[VW-1:0];
                `REG_POS_WINDOW: position_window_setting <= wr_data_in[VW-1:0];
                `REG_ROT_THR: rotation_threshold <= wr_data_in[VW-1:0];
                `REG_TORQUE_LVL: torque_level <= wr_data_in[VW-1:0];
                default: ctrl <= ctrl;
            endcase
        end
    end

    // ----------------------------------------
    // Register reads
    // ----------------------------------------
    assign status_word = {14'h0000, panel_ready_out, basic_mode_out,
        edit_open_out, edit_digit_out, state_code_out, bit_data_out};

    // Data stands the cycle after the strobe only; unmapped reads zero
    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rd_data_out <= 32'h00000000;
        end else if (rd_en_in) begin
            case (addr_in)
                `REG_CTRL: rd_data_out <= {29'h00000000, ctrl};
                `REG_SPEED_MATCH: rd_data_out <= {16'h0000, speed_match_threshold};
                `REG_POS_WINDOW: rd_data_out <= {16'h0000, position_window_setting};
                `REG_ROT_THR: rd_data_out <= {16'h0000, rotation_threshold};
                `REG_TORQUE_LVL: rd_data_out <= {16'h0000, torque_level};
                `REG_STATUS: rd_data_out <= status_word;
                `REG_EDIT_VALUE: rd_data_out <= {16'h0000, edit_value_out};
                default: rd_data_out <= 32'h00000000;
            endcase
        end else begin
            rd_data_out <= 32'h00000000;
        end
    end

endmodule

`default_nettype wire

// ### include/servo_panel_defines.vh
/*
 Constants for the servo front-panel block: register offsets, field
 positions, reset values, state codes and timing figures.
 Assumes it is included by its bare name from the design files.
*/
`ifndef SERVO_PANEL_DEFINES_VH
`define SERVO_PANEL_DEFINES_VH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define CLK_HZ 25000000
`define SETTLE_MS 100
`define DEBOUNCE_MS 10
`define SETTLE_CYC (`SETTLE_MS * (`CLK_HZ / 1000))
`define DEBOUNCE_CYC (`DEBOUNCE_MS * (`CLK_HZ / 1000))

// ----------------------------------------
// Register word offsets
// ----------------------------------------
`define REG_CTRL 4'h0
`define REG_SPEED_MATCH 4'h1
`define REG_POS_WINDOW 4'h2
`define REG_ROT_THR 4'h3
`define REG_TORQUE_LVL 4'h4
`define REG_STATUS 4'h5
`define REG_EDIT_VALUE 4'h6

// ----------------------------------------
// Control register fields and reset values
// ----------------------------------------
`define CTRL_MODE_LSB 0
`define CTRL_ALNUM_BIT 2
`define CTRL_RESET 3'h0
`define SPEED_MATCH_RESET 16'h000A
`define POS_WINDOW_RESET 16'h000A
`define ROT_THR_RESET 16'h0014
`define TORQUE_LVL_RESET 16'h000A

// ----------------------------------------
// Control modes
// ----------------------------------------
`define CM_SPEED 2'h0
`define CM_TORQUE 2'h1
`define CM_POSITION 2'h2

// ----------------------------------------
// Basic modes, in key order
// ----------------------------------------
`define BM_STATUS 2'h0
`define BM_PARAM 2'h1
`define BM_UTILITY 2'h2
`define BM_MONITOR 2'h3

// ----------------------------------------
// State codes
// ----------------------------------------
`define SC_INIT_FAIL 4'h0
`define SC_SERVO_OFF 4'h1
`define SC_READY 4'h2
`define SC_RUN 4'h3
`define SC_QUICK_STOP 4'h4
`define SC_ALARM 4'h5
`define SC_SAFE 4'h6
`define SC_FWD_PROHIBIT 4'h7
`define SC_REV_PROHIBIT 4'h8
`define SC_OVERTRAVEL 4'h9
`define SC_ALARM_NUM 4'hA

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define ST_BITS_LSB 0
`define ST_CODE_LSB 7
`define ST_DIGIT_LSB 11
`define ST_OPEN_BIT 14
`define ST_BMODE_LSB 15
`define ST_READY_BIT 17

`define LAST_DIGIT 3'h4

`endif

// ### tb/key_operator.sv
/*
 Operator model: presses one front key at a time, with contact bounce.
 Assumes HOLD exceeds the block's debounce count by a few cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module key_operator #(
    parameter HOLD = 6
) (
    input wire logic ref_clk_in,
    output logic [3:0] keys_out
);
    // Keys: 0 mode, 1 up, 2 down, 3 data
    initial keys_out = 4'h0;

    task automatic press(input logic [1:0] k);
        @(posedge ref_clk_in) keys_out[k] <= 1'b1;
        @(posedge ref_clk_in) keys_out[k] <= 1'b0;
        @(posedge ref_clk_in) keys_out[k] <= 1'b1;
        repeat (HOLD) @(posedge ref_clk_in);
        keys_out[k] <= 1'b0;
        repeat (HOLD) @(posedge ref_clk_in);
    endtask
endmodule
`default_nettype wire

// ### tb/servo_panel_checker.sv
/*
 Port-level checker for the panel block.
 Assumes one clock domain and a bind into the top design module.
*/
`timescale 1ns/1ps
`default_nettype none
`include "servo_panel_defines.vh"

module servo_panel_checker #(
    parameter VW = 16
) (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    input wire logic [31:0] rd_data_out,
    input wire logic servo_on_in,
    input wire logic control_power_in,
    input wire logic main_power_ok_in,
    input wire logic forward_travel_limit_in,
    input wire logic reverse_travel_limit_in,
    input wire logic init_fail_in,
    input wire logic alarm_in,
    input wire logic quick_stop_in,
    input wire logic safe_state_in,
    input wire logic [1:0] basic_mode_out,
    input wire logic [6:0] bit_data_out,
    input wire logic [3:0] state_code_out,
    input wire logic panel_ready_out,
    input wire logic edit_open_out,
    input wire logic [VW-1:0] edit_value_out,
    input wire logic alarm_clear_out
);
    // ----------------------------------------
    // Relations
    // ----------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);

    // Status shown on both edges, so the gating cannot race a mode change
    sequence s_disp;
        panel_ready_out && $past(panel_ready_out) && basic_mode_out == 2'h0 && $past(basic_mode_out) == 2'h0;
    endsequence

    property p_seg2; s_disp |-> bit_data_out[1] == !$past(servo_on_in); endproperty
    a_seg2: assert property (p_seg2) else $error("segment 2 wrong");
    property p_seg3; s_disp |-> bit_data_out[2] == $past(control_power_in); endproperty
    a_seg3: assert property (p_seg3) else $error("segment 3 wrong");
    property p_seg6; s_disp |-> bit_data_out[5] == $past(main_power_ok_in); endproperty
    a_seg6: assert property (p_seg6) else $error("segment 6 wrong");
    property p_dark; basic_mode_out != 2'h0 && $past(basic_mode_out) != 2'h0 |-> bit_data_out == 7'h00; endproperty
    a_dark: assert property (p_dark) else $error("segments lit outside status");
    property p_init; $past(rstn_in) && $past(init_fail_in) |-> state_code_out == `SC_INIT_FAIL; endproperty
    a_init: assert property (p_init) else $error("init fail code wrong");
    property p_fwd;
        $past(rstn_in) && $past({init_fail_in, alarm_in, safe_state_in, quick_stop_in,
            forward_travel_limit_in, reverse_travel_limit_in}) == 6'h02 |-> state_code_out == `SC_FWD_PROHIBIT;
    endproperty
    a_fwd: assert property (p_fwd) else $error("forward prohibit code wrong");
    property p_clear; alarm_clear_out |-> basic_mode_out == `BM_STATUS ##1 !alarm_clear_out; endproperty
    a_clear: assert property (p_clear) else $error("alarm clear pulse wrong");
    property p_mode; $changed(basic_mode_out) |-> basic_mode_out == $past(basic_mode_out) + 2'h1; endproperty
    a_mode: assert property (p_mode) else $error("mode step wrong");
    property p_edit; $changed(edit_value_out) && !$past(wr_en_in) |-> edit_open_out; endproperty
    a_edit: assert property (p_edit) else $error("value changed while closed");
    property p_ready; panel_ready_out |=> panel_ready_out; endproperty
    a_ready: assert property (p_ready) else $error("ready dropped");
    property p_rd; !$past(rd_en_in) |-> rd_data_out == 32'h0; endproperty
    a_rd: assert property (p_rd) else $error("read data outside its cycle");
endmodule

bind servo_panel_status_display servo_panel_checker #(.VW(VW)) servo_panel_checker_i (
    .ref_clk_in, .rstn_in, .wr_en_in, .rd_en_in, .rd_data_out, .servo_on_in, .control_power_in,
    .main_power_ok_in, .forward_travel_limit_in, .reverse_travel_limit_in, .init_fail_in, .alarm_in,
    .quick_stop_in, .safe_state_in, .basic_mode_out, .bit_data_out, .state_code_out, .panel_ready_out,
    .edit_open_out, .edit_value_out, .alarm_clear_out
);
`default_nettype wire

// ### tb/tb.sv
/*
 Testbench for the panel block: register port, keys and status display.
 Assumes the operator model and checker are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none
`include "servo_panel_defines.vh"

module tb;
    logic ref_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [3:0] addr_in;
    logic [31:0] wr_data_in;
    logic wr_en_in;
    logic rd_en_in;
    logic signed [15:0] motor_speed_in, speed_ref_in, torque_ref_in, position_error_in;
    logic [7:0] st;
    logic [2:0] fl;
    wire [3:0] keys;
    wire [31:0] rd_data_out;
    wire [1:0] basic_mode_out;
    wire [6:0] bit_data_out;
    wire [3:0] state_code_out;
    wire panel_ready_out, edit_open_out, alarm_clear_out;
    wire [2:0] edit_digit_out;
    wire [15:0] edit_value_out;
    int miscompares = 0, tests_run = 0;
    int i, v, b, nclr = 0;
    logic [31:0] d;
    logic signed [15:0] vm [3] = '{100, 20, -21};
    logic signed [15:0] vr [3] = '{110, -91, -11};
    logic signed [15:0] vt [3] = '{10, -11, 11};
    logic signed [15:0] ve [3] = '{9, -10, 10};
    logic [4:0] vf [3] = '{5'h15, 5'h0A, 5'h1F};
    logic [15:0] rv [5] = '{16'h0, `SPEED_MATCH_RESET, `POS_WINDOW_RESET, `ROT_THR_RESET, `TORQUE_LVL_RESET};
    logic [7:0] sv [10] = '{8'hFF, 8'h7F, 8'h3F, 8'h1F, 8'h0F, 8'h0B, 8'h07, 8'h03, 8'h01, 8'h00};
    logic [3:0] sx [10] = '{`SC_INIT_FAIL, `SC_ALARM, `SC_SAFE, `SC_QUICK_STOP, `SC_OVERTRAVEL,
        `SC_FWD_PROHIBIT, `SC_REV_PROHIBIT, `SC_RUN, `SC_READY, `SC_SERVO_OFF};

    // Short counts keep the run brief
    servo_panel_status_display #(.SETTLE_CYC(10), .DEBOUNCE_CYC(3), .VW(16)) servo_panel_status_display_i (
        .ref_clk_in, .rstn_in, .addr_in, .wr_data_in, .wr_en_in, .rd_en_in, .rd_data_out,
        .key_mode_in(keys[0]), .key_up_in(keys[1]), .key_down_in(keys[2]), .key_data_in(keys[3]),
        .motor_speed_in, .speed_ref_in, .torque_ref_in, .position_error_in,
        .ref_pulse_active_in(fl[2]), .deviation_clear_in(fl[1]), .control_power_in(fl[0]),
        .init_fail_in(st[7]), .alarm_in(st[6]), .safe_state_in(st[5]), .quick_stop_in(st[4]),
        .forward_travel_limit_in(st[3]), .reverse_travel_limit_in(st[2]), .servo_on_in(st[1]),
        .main_power_ok_in(st[0]), .basic_mode_out, .bit_data_out, .state_code_out, .panel_ready_out,
        .edit_open_out, .edit_digit_out, .edit_value_out, .alarm_clear_out
    );
    key_operator #(.HOLD(6)) op_i (.ref_clk_in, .keys_out(keys));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Clock, 25 MHz
    initial begin
        forever #20 ref_clk_in = ~ref_clk_in;
    end
    // Count one-cycle alarm clear pulses
    always @(posedge ref_clk_in) begin
        if (alarm_clear_out === 1'b1) nclr <= nclr + 1;
    end

    function automatic int ab(input int x);
        return x < 0 ? -x : x;
    endfunction
    // Segment image, thresholds at defaults except rotation
    function automatic logic [6:0] exp_bits(input int cm, input int rot);
        logic s1, s4, s5;
        s1 = cm == 1 ? 1'b1 : cm == 0 ? ab(motor_speed_in - speed_ref_in) <= 10 : ab(position_error_in) < 10;
        s4 = cm == 2 ? fl[2] : ab(speed_ref_in) > rot;
        s5 = cm == 2 ? fl[1] : ab(torque_ref_in) > 10;
        return {ab(motor_speed_in) > rot, st[0], s5, s4, fl[0], !st[1], s1};
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task wr_reg(input logic [3:0] a, input logic [31:0] x);
        @(posedge ref_clk_in);
        addr_in <= a;
        wr_data_in <= x;
        wr_en_in <= 1'b1;
        @(posedge ref_clk_in);
        wr_en_in <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task rd_reg(input logic [3:0] a, output logic [31:0] x);
        @(posedge ref_clk_in);
        addr_in <= a;
        rd_en_in <= 1'b1;
        @(posedge ref_clk_in);
        rd_en_in <= 1'b0;
        #1 x = rd_data_out;
    endtask
    task settle;
        repeat (2) @(posedge ref_clk_in);
        #1;
    endtask
    task end_sim;
        $display("compares %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Watchdog, well past the test length
    initial begin
        #(40 * 20000);
        miscompares++;
        end_sim;
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        {addr_in, wr_data_in, wr_en_in, rd_en_in} = 38'h0;
        {motor_speed_in, speed_ref_in, torque_ref_in, position_error_in} = 64'h0;
        st = 8'h00;
        fl = 3'h0;
        repeat (5) @(posedge ref_clk_in);
        #1;
        chk(state_code_out, `SC_SERVO_OFF, "reset code");
        @(posedge ref_clk_in) rstn_in <= 1'b1;
        for (i = 0; i < 40 && panel_ready_out !== 1'b1; i++) @(posedge ref_clk_in);
        #1;
        chk(panel_ready_out, 1, "ready");
        chk(basic_mode_out, `BM_STATUS, "start mode");
        for (i = 1; i < 5; i++) begin
            rd_reg(i[3:0], d);
            chk(d, rv[i], "reset value");
        end
        wr_reg(4'hF, 32'h1234);
        rd_reg(4'hF, d);
        chk(d, 0, "unmapped");
        $display("test registers done");
        for (b = 0; b < 3; b++) begin
            wr_reg(`REG_CTRL, b);
            for (v = 0; v < 3; v++) begin
                @(posedge ref_clk_in);
                motor_speed_in <= vm[v];
                speed_ref_in <= vr[v];
                torque_ref_in <= vt[v];
                position_error_in <= ve[v];
                {fl, st[1:0]} <= vf[v];
                settle;
                chk(bit_data_out, exp_bits(b, 20), "segments");
            end
        end
        wr_reg(`REG_CTRL, 32'h3);
        wr_reg(`REG_ROT_THR, 150);
        @(posedge ref_clk_in) motor_speed_in <= -150;
        settle;
        chk(bit_data_out, exp_bits(0, 150), "rotation threshold");
        $display("test segments done");
        for (i = 0; i < 10; i++) begin
            @(posedge ref_clk_in) st <= sv[i];
            settle;
            chk(state_code_out, sx[i], "state code");
        end
        wr_reg(`REG_CTRL, 32'h4);
        @(posedge ref_clk_in) st <= 8'h40;
        settle;
        chk(state_code_out, `SC_ALARM_NUM, "alarm number");
        wr_reg(`REG_CTRL, 32'h0);
        $display("test codes done");
        op_i.press(2'd1);
        chk(edit_value_out, 0, "up refused");
        for (i = 1; i < 5; i++) begin
            op_i.press(2'd0);
            chk(basic_mode_out, i % 4, "mode step");
        end
        op_i.press(2'd0);
        op_i.press(2'd3);
        chk({edit_open_out, edit_digit_out}, 4'h8, "open");
        op_i.press(2'd1);
        chk(edit_value_out, 16'h0001, "up");
        op_i.press(2'd3);
        chk(edit_digit_out, 1, "shift");
        op_i.press(2'd1);
        op_i.press(2'd2);
        op_i.press(2'd2);
        chk(edit_value_out, 16'hFFF7, "down wrap");
        for (i = 0; i < 4; i++) op_i.press(2'd3);
        chk(edit_digit_out, 0, "digit wrap");
        op_i.press(2'd2);
        rd_reg(`REG_EDIT_VALUE, d);
        chk(d, 32'hFFF6, "edit read");
        for (i = 0; i < 3; i++) op_i.press(2'd0);
        chk({basic_mode_out, edit_open_out}, 3'h0, "back to status");
        $display("test keys done");
        b = nclr;
        op_i.press(2'd3);
        chk(nclr - b, 1, "alarm clear");
        @(posedge ref_clk_in) st <= 8'h00;
        op_i.press(2'd3);
        chk(nclr - b, 1, "no alarm");
        rd_reg(`REG_STATUS, d);
        chk(d, {14'h0, 1'b1, 6'h00, `SC_SERVO_OFF, exp_bits(0, 150)}, "status word");
        $display("test alarm done");
        end_sim;
    end
endmodule
`default_nettype wire
